// ===== logic/rdsh_dec_port.sv
// rdsh_dec_port: decoder-clock side, picks blocks to present and holds settings
// assumes: block_stb is a one-cycle pulse on dclk; ack and ctrl toggles come from clk
`timescale 1ns/1ps
module rdsh_dec_port (
  input  wire logic        dclk,
  input  wire logic        rst,
  input  wire logic        block_stb,
  input  wire logic [2:0]  block_id,
  input  wire logic [15:0] block_word,
  input  wire logic [1:0]  block_err,
  input  wire logic        synced,
  input  wire logic        ack_tgl,
  input  wire logic        ctrl_tgl,
  input  wire logic [7:0]  shadow_mode,
  input  wire logic [7:0]  shadow_level,
  input  wire logic [7:0]  shadow_time,
  output logic             req_tgl_r,
  output logic [15:0]      h_last_r,
  output logic [15:0]      h_prev_r,
  output logic [2:0]       h_id_r,
  output logic [1:0]       h_err_r,
  output logic [1:0]       h_prev_err_r,
  output logic             h_sync_r,
  output logic             h_ovf_r,
  output logic [7:0]       mode_r,
  output logic [7:0]       level_r,
  output logic [7:0]       time_r
);
  import rdsh_pkg::*;

  logic        ack_s1_r, ack_s2_r, ctl_s1_r, ctl_s2_r, ctl_q_r;
  logic        pair_r, ovf_pend_r, present, busy;
  logic [15:0] last_word_r;
  logic [1:0]  last_err_r;
  rdsh_proto_t proto;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge dclk or posedge rst) begin
    if (rst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ctl_s1_r <= 1'b0;
      ctl_s2_r <= 1'b0;
      ctl_q_r  <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl;
      ack_s2_r <= ack_s1_r;
      ctl_s1_r <= ctrl_tgl;
      ctl_s2_r <= ctl_s1_r;
      ctl_q_r  <= ctl_s2_r;
    end
  end

  // settings change only at a handshake, so the shadow is stable when latched
  always_ff @(posedge dclk or posedge rst) begin
    if (rst) begin
      mode_r  <= MODE_RST;
      level_r <= LEVEL_RST;
      time_r  <= TIME_RST;
    end else if (ctl_s2_r != ctl_q_r) begin
      mode_r  <= shadow_mode;
      level_r <= shadow_level;
      time_r  <= shadow_time;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign proto = rdsh_proto_t'(mode_r[B_PROT_HI:B_PROT_LO]);
  assign busy  = req_tgl_r ^ ack_s2_r;

  // code 11 is treated as the standard protocol
  always_comb begin
    case (proto)
      fast_id_search_protocol:
        present = synced | (block_id == BLOCK_A && block_err == ERR_NONE);
      reduced_request_protocol:
        present = synced & pair_r;
      default:
        present = synced;
    endcase
  end

  always_ff @(posedge dclk or posedge rst) begin
    if (rst) begin
      pair_r      <= 1'b0;
      last_word_r <= 16'h0000;
      last_err_r  <= 2'h0;
    end else if (block_stb) begin
      pair_r      <= synced & ~pair_r;
      last_word_r <= block_word;
      last_err_r  <= block_err;
    end
  end

  // a block that cannot be handed over while the previous one is pending
  // is dropped and reported as overflow with the next one that gets through
  always_ff @(posedge dclk or posedge rst) begin
    if (rst) begin
      req_tgl_r    <= 1'b0;
      ovf_pend_r   <= 1'b0;
      h_last_r     <= 16'h0000;
      h_prev_r     <= 16'h0000;
      h_id_r       <= 3'h0;
      h_err_r      <= 2'h0;
      h_prev_err_r <= 2'h0;
      h_sync_r     <= 1'b0;
      h_ovf_r      <= 1'b0;
    end else if (block_stb && present) begin
      if (busy) begin
        ovf_pend_r <= 1'b1;
      end else begin
        req_tgl_r    <= ~req_tgl_r;
        ovf_pend_r   <= 1'b0;
        h_last_r     <= block_word;
        h_prev_r     <= last_word_r;
        h_id_r       <= block_id;
        h_err_r      <= block_err;
        h_prev_err_r <= last_err_r;
        h_sync_r     <= synced;
        h_ovf_r      <= ovf_pend_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge dclk); endclocking
  default disable iff (rst);

  search_silent_a: assert property (block_stb && !synced && proto != fast_id_search_protocol
    |=> $stable(req_tgl_r)) else $error("block handed over during search");
  fast_a_block_a: assert property (block_stb && !synced && !busy && block_err == ERR_NONE
    && block_id == BLOCK_A && proto == fast_id_search_protocol
    |=> req_tgl_r != $past(req_tgl_r)) else $error("clean A block not presented");

endmodule // rdsh_dec_port

// ===== logic/rdsh_host_regs.sv
// rdsh_host_regs: two-wire slave with three control and seven status bytes
// assumes: clk is much faster than scl; decoder logic runs on dclk
//
// Overview of operation
// - data_ready_n goes low whenever fresh block data lands in the read bank.
// - three writable control bytes and seven readable bytes behind the slave port.
// - on each new block, refresh read bank and hand current settings to decoder.
// - block updates wait while a host read is in progress.
// - separate write and read pointers, moved only by bus transfers.
// - pointer picks the first byte, then advances by one per byte.
// - reads deliver status, last high/low, previous high/low, errors, quality.
// - mode bit 7 picks triggered or continuous quality measurement.
// - mode bit 6 requests a quality measurement.
// - mode bit 5 forces a restart of block synchronisation.
// - mode bits 4:3 pick correction used during synchronisation search.
// - mode bit 2 picks rds or rbds processing.
// - protocol 00 presents every block once synchronised, none during search.
// - protocol 01 also presents clean A blocks during search.
// - protocol 10 presents only every second block once synchronised.
// - second byte bits 7:6 set the pause threshold.
// - second byte bits 5:0 hold the flywheel limit.
// - third byte bit 5 says what bits 7:6 mean.
// - third byte bits 7:6 give pause time or oscillator multiple.
// - third byte bits 4:0 set quality detector sensitivity.
// - control bytes take their documented defaults at reset.
`timescale 1ns/1ps
module rdsh_host_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dclk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             data_ready_n,
  input  wire logic        block_stb,
  input  wire logic [2:0]  block_id,
  input  wire logic [15:0] block_word,
  input  wire logic [1:0]  block_err,
  input  wire logic        synced,
  input  wire logic [5:0]  error_count,
  input  wire logic [3:0]  quality_level,
  output logic             quality_continuous_sel,
  output logic             quality_trigger,
  output logic             sync_restart,
  output logic [1:0]       search_correction,
  output logic             rbds_mode,
  output rdsh_pkg::rdsh_proto_t output_protocol,
  output logic [1:0]       pause_threshold,
  output logic [5:0]       flywheel_limit,
  output logic [1:0]       time_or_freq,
  output logic             freq_select_meaning,
  output logic [4:0]       quality_sensitivity
);
  import rdsh_pkg::*;

  logic [2:0]  scl_sh_r, sda_sh_r;
  logic        scl_f_r, sda_f_r, scl_q_r, sda_q_r;
  logic        scl_rise, scl_fall, start_cond, stop_cond;
  rdsh_i2c_t   state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r, tx_r;
  logic        rw_r, nack_r, sda_oe_n_r;
  logic [1:0]  wptr_r;
  logic [2:0]  rptr_r;
  logic        wr_stb, rd_load, rd_busy, write_done;
  logic [7:0]  wr_bank_r [NUM_WR];
  logic [7:0]  rd_bank_r [NUM_RD];
  logic [7:0]  shadow_r  [NUM_WR];
  logic        rstd_r, dav_n_r;
  logic        req_s1_r, req_s2_r, ack_tgl_r, ctrl_tgl_r, take;
  logic [5:0]  count_s1_r, count_s2_r;
  logic [3:0]  qual_s1_r, qual_s2_r;
  logic        req_tgl;
  logic [15:0] h_last, h_prev;
  logic [2:0]  h_id;
  logic [1:0]  h_err, h_prev_err;
  logic        h_sync, h_ovf;
  logic [7:0]  mode_d, level_d, time_d;

  function automatic logic [7:0] rd_byte(input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx == 3'h0) begin
      b = rd_bank_r[0];
      b[B_RSTD] = rstd_r;
    end else if (idx <= RD_LAST) begin
      b = rd_bank_r[idx];
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin filter: a level counts once the second and third stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sh_r <= 3'h7;
      sda_sh_r <= 3'h7;
      scl_f_r  <= 1'b1;
      sda_f_r  <= 1'b1;
      scl_q_r  <= 1'b1;
      sda_q_r  <= 1'b1;
    end else begin
      scl_sh_r <= {scl_sh_r[1:0], scl_in};
      sda_sh_r <= {sda_sh_r[1:0], sda_in};
      if (scl_sh_r[2] == scl_sh_r[1]) begin
        scl_f_r <= scl_sh_r[2];
      end
      if (sda_sh_r[2] == sda_sh_r[1]) begin
        sda_f_r <= sda_sh_r[2];
      end
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end

  assign scl_rise   = scl_f_r & ~scl_q_r;
  assign scl_fall   = ~scl_f_r & scl_q_r;
  assign start_cond = ~sda_f_r & sda_q_r & scl_f_r & scl_q_r;
  assign stop_cond  = sda_f_r & ~sda_q_r & scl_f_r & scl_q_r;

  //////////////////////////////////////////////////////////////////////////////
  // byte engine; the line is only ever pulled low or released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'h00;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_cond) begin
      state_r    <= ST_ADDR;
      bit_cnt_r  <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_cond) begin
      state_r    <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      case (state_r)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_f_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
            if (state_r == ST_WRITE) begin
              state_r    <= ST_ACK_WR;
              sda_oe_n_r <= 1'b0;
            end else if (shift_r[7:1] == SLAVE_ADDR) begin
              state_r    <= ST_ACK_ADDR;
              rw_r       <= shift_r[0];
              sda_oe_n_r <= 1'b0;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ACK_ADDR && rw_r) begin
              state_r    <= ST_READ;
              tx_r       <= rd_byte(rptr_r);
              sda_oe_n_r <= rd_byte(rptr_r) >> 7 == 8'h01;
            end else begin
              state_r    <= ST_WRITE;
              sda_oe_n_r <= 1'b1;
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_r == BITS_PER_BYTE) begin
              state_r    <= ST_RD_ACK;
              sda_oe_n_r <= 1'b1;
            end else begin
              tx_r       <= {tx_r[6:0], 1'b0};
              sda_oe_n_r <= tx_r[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_f_r;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              state_r    <= ST_READ;
              tx_r       <= rd_byte(rptr_r);
              sda_oe_n_r <= rd_byte(rptr_r) >> 7 == 8'h01;
            end
          end
        end
        default: begin
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  assign wr_stb     = state_r == ST_WRITE && scl_fall && bit_cnt_r == BITS_PER_BYTE;
  assign rd_load    = scl_fall && ((state_r == ST_ACK_ADDR && rw_r)
                      || (state_r == ST_RD_ACK && !nack_r));
  assign rd_busy    = state_r == ST_READ || state_r == ST_RD_ACK
                      || (state_r == ST_ACK_ADDR && rw_r);
  assign write_done = stop_cond && (state_r == ST_WRITE || state_r == ST_ACK_WR);

  //////////////////////////////////////////////////////////////////////////////
  // pointers restart at the first byte of every transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_r <= 2'h0;
      rptr_r <= 3'h0;
    end else if (start_cond) begin
      wptr_r <= 2'h0;
      rptr_r <= 3'h0;
    end else begin
      if (wr_stb && wptr_r <= WR_LAST) begin
        wptr_r <= wptr_r + 2'h1;
      end
      if (rd_load && rptr_r <= RD_LAST) begin
        rptr_r <= rptr_r + 3'h1;
      end
    end
  end

  // bytes past the last control byte are acknowledged and dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_bank_r[0] <= MODE_RST;
      wr_bank_r[1] <= LEVEL_RST;
      wr_bank_r[2] <= TIME_RST;
    end else if (wr_stb && wptr_r <= WR_LAST) begin
      wr_bank_r[wptr_r] <= shift_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoder handshake: req toggles on dclk, ack and ctrl toggle back from clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      count_s1_r <= 6'h00;
      count_s2_r <= 6'h00;
      qual_s1_r  <= 4'h0;
      qual_s2_r  <= 4'h0;
    end else begin
      req_s1_r   <= req_tgl;
      req_s2_r   <= req_s1_r;
      count_s1_r <= error_count;
      count_s2_r <= count_s1_r;
      qual_s1_r  <= quality_level;
      qual_s2_r  <= qual_s1_r;
    end
  end

  assign take = (req_s2_r != ack_tgl_r) && !rd_busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_tgl_r <= 1'b0;
      for (int i = 0; i < NUM_RD; i++) begin
        rd_bank_r[i] <= 8'h00;
      end
    end else if (take) begin
      ack_tgl_r    <= ~ack_tgl_r;
      rd_bank_r[0] <= {h_id, h_sync, h_ovf, 1'b0, h_err};
      rd_bank_r[1] <= h_last[15:8];
      rd_bank_r[2] <= h_last[7:0];
      rd_bank_r[3] <= h_prev[15:8];
      rd_bank_r[4] <= h_prev[7:0];
      rd_bank_r[5] <= {count_s2_r, h_prev_err};
      rd_bank_r[6] <= {4'h0, qual_s2_r};
    end
  end

  // settings reach the decoder with each block and after each host write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_tgl_r  <= 1'b0;
      shadow_r[0] <= MODE_RST;
      shadow_r[1] <= LEVEL_RST;
      shadow_r[2] <= TIME_RST;
    end else if (take || write_done) begin
      ctrl_tgl_r <= ~ctrl_tgl_r;
      for (int i = 0; i < NUM_WR; i++) begin
        shadow_r[i] <= wr_bank_r[i];
      end
    end
  end

  // new data wins over the host's read of the status byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dav_n_r <= 1'b1;
      rstd_r  <= 1'b1;
    end else begin
      if (take) begin
        dav_n_r <= 1'b0;
      end else if (rd_load && rptr_r == 3'h0) begin
        dav_n_r <= 1'b1;
      end
      if (rd_load && rptr_r == 3'h0) begin
        rstd_r <= 1'b0;
      end
    end
  end

  rdsh_dec_port u_dec (
    .dclk         (dclk),
    .rst          (rst),
    .block_stb    (block_stb),
    .block_id     (block_id),
    .block_word   (block_word),
    .block_err    (block_err),
    .synced       (synced),
    .ack_tgl      (ack_tgl_r),
    .ctrl_tgl     (ctrl_tgl_r),
    .shadow_mode  (shadow_r[0]),
    .shadow_level (shadow_r[1]),
    .shadow_time  (shadow_r[2]),
    .req_tgl_r    (req_tgl),
    .h_last_r     (h_last),
    .h_prev_r     (h_prev),
    .h_id_r       (h_id),
    .h_err_r      (h_err),
    .h_prev_err_r (h_prev_err),
    .h_sync_r     (h_sync),
    .h_ovf_r      (h_ovf),
    .mode_r       (mode_d),
    .level_r      (level_d),
    .time_r       (time_d)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign sda_out                = 1'b0;
  assign sda_oe_n               = sda_oe_n_r;
  assign data_ready_n           = dav_n_r;
  assign quality_continuous_sel = mode_d[B_QCONT];
  assign quality_trigger        = mode_d[B_QTRIG];
  assign sync_restart           = mode_d[B_RESTART];
  assign search_correction      = mode_d[B_CORR_HI:B_CORR_LO];
  assign rbds_mode              = mode_d[B_RBDS];
  assign output_protocol        = rdsh_proto_t'(mode_d[B_PROT_HI:B_PROT_LO]);
  assign pause_threshold        = level_d[B_PL_HI:B_PL_LO];
  assign flywheel_limit         = level_d[B_FLY_HI:0];
  assign time_or_freq           = time_d[B_TF_HI:B_TF_LO];
  assign freq_select_meaning    = time_d[B_FSEL];
  assign quality_sensitivity    = time_d[B_SENS_HI:0];

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  dav_on_take_a: assert property (take |=> !data_ready_n)
    else $error("data ready not asserted");
  read_holds_bank_a: assert property (rd_busy |=> $stable(rd_bank_r[1]))
    else $error("bank changed during read");
  wptr_step_a: assert property (wr_stb && wptr_r <= WR_LAST |=> wptr_r == $past(wptr_r) + 2'h1)
    else $error("write pointer did not advance");
  ptr_restart_a: assert property (start_cond |=> wptr_r == 2'h0 && rptr_r == 3'h0)
    else $error("pointers not restarted");
  addr_ack_a: assert property (state_r == ST_ADDR ##1 state_r == ST_ACK_ADDR |-> !sda_oe_n)
    else $error("address not acknowledged");
  settings_push_a: assert property (take |=> ctrl_tgl_r != $past(ctrl_tgl_r))
    else $error("settings not handed over");
  mode_store_a: assert property (wr_stb && wptr_r == 2'h0 |=> wr_bank_r[0] == $past(shift_r))
    else $error("mode byte not stored");
  status_first_a: assert property (rd_load && rptr_r == 3'h0 |=> tx_r[7:3] == rd_bank_r[0][7:3])
    else $error("status byte not first");
  reset_flag_a: assert property (rd_load && rptr_r == 3'h0 && !take |=> !rstd_r ##1 !rstd_r)
    else $error("reset flag not cleared");

  take_cov_c: cover property (take ##[1:1000] rd_load);
  write_cov_c: cover property (wr_stb && wptr_r == WR_LAST);
  nack_cov_c: cover property (state_r == ST_RD_ACK && scl_fall && nack_r);

endmodule // rdsh_host_regs

// ===== logic/rdsh_pkg.sv
// rdsh_pkg: shared constants and types of the rds host register bank
// assumes: byte-wide control and status registers behind a two-wire slave port
package rdsh_pkg;

  localparam int NUM_WR = 3;
  localparam int NUM_RD = 7;
  localparam logic [1:0] WR_LAST = 2'h2;
  localparam logic [2:0] RD_LAST = 3'h6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // slave address, value is arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h2a;

  // reset values of the three control bytes
  localparam logic [7:0] MODE_RST  = 8'h20;
  localparam logic [7:0] LEVEL_RST = 8'h20;
  localparam logic [7:0] TIME_RST  = 8'h0f;

  // control byte field positions
  localparam int B_QCONT   = 7;
  localparam int B_QTRIG   = 6;
  localparam int B_RESTART = 5;
  localparam int B_CORR_HI = 4;
  localparam int B_CORR_LO = 3;
  localparam int B_RBDS    = 2;
  localparam int B_PROT_HI = 1;
  localparam int B_PROT_LO = 0;
  localparam int B_PL_HI   = 7;
  localparam int B_PL_LO   = 6;
  localparam int B_FLY_HI  = 5;
  localparam int B_TF_HI   = 7;
  localparam int B_TF_LO   = 6;
  localparam int B_FSEL    = 5;
  localparam int B_SENS_HI = 4;

  // status byte field positions
  localparam int B_RSTD = 2;

  localparam logic [2:0] BLOCK_A  = 3'h0;
  localparam logic [1:0] ERR_NONE = 2'h0;

  typedef enum logic [1:0] {
    standard_output_protocol = 2'h0,
    fast_id_search_protocol  = 2'h1,
    reduced_request_protocol = 2'h2,
    undefined_protocol       = 2'h3
  } rdsh_proto_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ACK_ADDR = 3'h2,
    ST_WRITE    = 3'h3,
    ST_ACK_WR   = 3'h4,
    ST_READ     = 3'h5,
    ST_RD_ACK   = 3'h6
  } rdsh_i2c_t;

endpackage

// ===== testbench/rds_host_register_interface_bench.sv
// bench for rdsh_host_regs: bus writes and reads, decoder blocks on dclk
// assumes: rdsh_i2c_master drives the bus pins; decoder side driven here
`timescale 1ns/1ps
module rds_host_register_interface_bench;
  import rdsh_pkg::*;
  logic        clk, rst, dclk, block_stb, synced, sda_out, sda_oe_n, data_ready_n;
  logic        m_scl, m_sda, quality_continuous_sel, quality_trigger, sync_restart;
  logic        rbds_mode, freq_select_meaning;
  logic [2:0]  block_id;
  logic [15:0] block_word;
  logic [1:0]  block_err, search_correction, pause_threshold, time_or_freq;
  logic [5:0]  error_count, flywheel_limit;
  logic [3:0]  quality_level;
  logic [4:0]  quality_sensitivity;
  rdsh_proto_t output_protocol;
  localparam logic [63:0] RD_EXP = 64'h04be_ef12_3415_0900;
  logic [7:0]  rb [8];
  int          error_cnt, samples_checked;
  wire         sda_w = m_sda & (sda_oe_n | sda_out);
  wire [7:0]   mode_o = {quality_continuous_sel, quality_trigger, sync_restart,
                         search_correction, rbds_mode, output_protocol};
  wire [7:0]   lvl_o = {pause_threshold, flywheel_limit};
  wire [7:0]   tim_o = {time_or_freq, freq_select_meaning, quality_sensitivity};

  rdsh_i2c_master m_u (.clk(clk), .sda(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  rdsh_host_regs dut_u (.clk(clk), .rst(rst), .dclk(dclk), .scl_in(m_scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .data_ready_n(data_ready_n),
    .block_stb(block_stb), .block_id(block_id), .block_word(block_word),
    .block_err(block_err), .synced(synced), .error_count(error_count),
    .quality_level(quality_level), .quality_continuous_sel(quality_continuous_sel),
    .quality_trigger(quality_trigger), .sync_restart(sync_restart),
    .search_correction(search_correction), .rbds_mode(rbds_mode),
    .output_protocol(output_protocol), .pause_threshold(pause_threshold),
    .flywheel_limit(flywheel_limit), .time_or_freq(time_or_freq),
    .freq_select_meaning(freq_select_meaning), .quality_sensitivity(quality_sensitivity));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // settings reach the decoder-side outputs some dclk cycles after stop
  task automatic wr3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    logic [7:0] q;
    logic       k;
    m_u.start();
    m_u.xbyte({SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    chk({7'h0, k}, 8'h00);
    m_u.xbyte(a, 1'b1, q, k);
    m_u.xbyte(b, 1'b1, q, k);
    m_u.xbyte(c, 1'b1, q, k);
    chk({7'h0, k}, 8'h00);
    m_u.stop();
    repeat (20) @(posedge dclk);
  endtask
  task automatic rd(input int n);
    logic k;
    m_u.start();
    m_u.xbyte({SLAVE_ADDR, 1'b1}, 1'b1, rb[0], k);
    chk({7'h0, k}, 8'h00);
    for (int i = 0; i < n; i++) m_u.xbyte(8'hff, i == n - 1, rb[i], k);
    m_u.stop();
  endtask
  // one block in flight at a time: wait well past the take before the next
  task automatic blk(input logic [2:0] id, input logic [15:0] wd, input logic [1:0] er,
                     input logic sy);
    @(posedge dclk);
    block_stb <= 1'b1;
    block_id <= id;
    block_word <= wd;
    block_err <= er;
    synced <= sy;
    @(posedge dclk);
    block_stb <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    dclk = 1'b0;
    #1.3;
    forever #7.5 dclk = ~dclk;
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    block_stb = 1'b0;
    block_id = 3'h0;
    block_word = 16'h0000;
    block_err = 2'h0;
    synced = 1'b0;
    error_count = 6'h05;
    quality_level = 4'h9;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(mode_o, 8'h20);
    chk(lvl_o, 8'h20);
    chk(tim_o, 8'h0f);
    chk({7'h0, data_ready_n}, 8'h01);
    wr3(8'hd9, 8'h9b, 8'he6);
    chk(mode_o, 8'hd9);
    chk(lvl_o, 8'h9b);
    chk(tim_o, 8'he6);
    for (int i = 0; i < 4; i++) begin
      wr3({3'b011, 2'(i), i[0], 1'b0, i[1]}, 8'h5f, 8'h3f);
      chk(mode_o, {3'b011, 2'(i), i[0], 1'b0, i[1]});
    end
    m_u.start();
    m_u.xbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, rb[0], rb[1][0]);
    m_u.stop();
    chk({7'h0, rb[1][0]}, 8'h01);
    wr3(8'h01, 8'h20, 8'h0f);
    blk(3'h1, 16'h1234, 2'h1, 1'b0);
    chk({7'h0, data_ready_n}, 8'h01);
    blk(3'h0, 16'hbeef, 2'h0, 1'b0);
    chk({7'h0, data_ready_n}, 8'h00);
    rd(8);
    chk({7'h0, data_ready_n}, 8'h01);
    foreach (rb[i]) chk(rb[i], RD_EXP[63 - 8 * i -: 8]);
    wr3(8'h00, 8'h20, 8'h0f);
    blk(3'h2, 16'h0f0f, 2'h0, 1'b0);
    chk({7'h0, data_ready_n}, 8'h01);
    blk(3'h2, 16'h5a5a, 2'h0, 1'b1);
    chk({7'h0, data_ready_n}, 8'h00);
    rd(3);
    chk(rb[0], 8'h50);
    chk(rb[1], 8'h5a);
    wr3(8'h02, 8'h20, 8'h0f);
    for (int i = 0; i < 3 && data_ready_n === 1'b1; i++) blk(3'h1, 16'h0001, 2'h0, 1'b1);
    rd(1);
    blk(3'h2, 16'h0002, 2'h0, 1'b1);
    chk({7'h0, data_ready_n}, 8'h01);
    blk(3'h3, 16'h0003, 2'h0, 1'b1);
    chk({7'h0, data_ready_n}, 8'h00);
    complete_run();
  end
endmodule // rds_host_register_interface_bench

// ===== testbench/rdsh_i2c_master.sv
// rdsh_i2c_master: behavioural two-wire bus master for the register bank
// assumes: sda is the wired-and of all parties with a pull-up; scl idles high
`timescale 1ns/1ps
module rdsh_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start: data falls while clock high
  task automatic start();
    w(8);
    sda_o <= 1'b0;
    w(8);
    scl_o <= 1'b0;
    w(8);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    w(8);
    scl_o <= 1'b1;
    w(8);
    sda_o <= 1'b1;
    w(8);
  endtask
  // data moves only while clock is low; slave answer lags scl fall by its filter
  task automatic xbit(input logic b, output logic r);
    sda_o <= b;
    w(8);
    scl_o <= 1'b1;
    w(8);
    r = sda;
    scl_o <= 1'b0;
    w(8);
  endtask
  // msb first, ninth bit is the acknowledge
  task automatic xbyte(input logic [7:0] d, input logic nak, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(nak, ack);
  endtask
endmodule // rdsh_i2c_master
